// ### hdl/blhbc_bus.sv
module blhbc_bus #(
    parameter int unsigned SELFTEST_CYCLES = blhbc_pkg::SELFTEST_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        selftest_ok_i,           // self-test verdict
    input  wire logic        req_i,                   // core transfer request, level
    input  wire logic        req_write_i,             // plain write
    input  wire logic        req_atomic_i,            // locked read then write
    input  wire logic        req_iack_i,              // interrupt-acknowledge read
    input  wire logic [2:0]  req_beats_i,             // beats minus one
    input  wire logic [1:0]  req_lanes_n_i,           // lanes wanted, low active
    output logic             req_done_o,              // transfer finished pulse
    input  wire logic [15:0] rd_data_i,               // read data from memory
    input  wire logic        ready_n_i,               // memory ready, low active
    input  wire logic        hold_i,                  // external master request
    input  wire logic        lock_in_i,               // lock line level, low asserted
    output logic             lock_out_o,              // lock line drive value
    output logic             lock_oe_n_o,             // lock drive enable, low drives
    output logic [1:0]       byte_lane_enables_n_o,   // upper, lower lane
    output logic             burst_final_strobe_n_o,  // last beat / error
    output logic             bus_grant_ack_o,         // hold granted
    output logic             bus_grant_ack_oe_n_o,    // grant ack drive, low drives
    output logic             bus_float_o,             // three-state bus pins released
    output logic             address_state_o,         // in address state
    output logic             data_state_o,            // in data or wait state
    output logic             write_o,                 // current transfer writes
    output logic             init_fail_o              // start-up error seen
);
    blhbc_init_if init ();

    blhbc_pkg::blhbc_bus_state_t st;         // bus state
    blhbc_pkg::blhbc_bus_state_t next_st;    // next bus state
    logic [2:0]  beat;                       // current beat
    logic [2:0]  last;                       // final beat index
    logic [1:0]  lanes_n;                    // lanes of this transfer
    logic        xwrite;                     // transfer direction
    logic        xatomic;                    // part of an atomic update
    logic        xiack;                      // interrupt acknowledge
    logic        xcks;                       // start-up checksum burst
    logic        lock_held;                  // we pull the lock line
    logic        next_lock;                  // lock drive next cycle
    logic        once;                       // emulator float mode
    logic        beat_ok;                    // data accepted this cycle
    logic        start_user;                 // user transfer begins
    logic        start_cks;                  // checksum burst begins
    logic        finish;                     // last beat accepted

    blhbc_init #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_init (
        .mclk_i        (mclk_i),
        .rstn_i        (rstn_i),
        .selftest_ok_i (selftest_ok_i),
        .init          (init.startup)
    );

    // data or wait, decoded in several places
    function automatic logic in_data(input blhbc_pkg::blhbc_bus_state_t s);
        in_data = (s == blhbc_pkg::S_DATA) || (s == blhbc_pkg::S_WAIT);
    endfunction

    // ********************************************************
    // emulator mode capture
    // ********************************************************
    // lock level tracked through reset; last sample before release wins
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            once <= !lock_in_i;
        end
    end

    // ********************************************************
    // next-state decode
    // ********************************************************
    assign beat_ok    = in_data(st) && !ready_n_i;
    assign finish     = beat_ok && (beat == last);
    assign start_cks  = init.cks_req && !hold_i && !once;
    // run only after checksum passed; no transfer while error shown
    assign start_user = req_i && !init.fail && !init.cks_req && !hold_i && !once;

    always_comb begin
        next_st = st;
        case (st)
            blhbc_pkg::S_IDLE: begin
                if (hold_i) begin
                    next_st = blhbc_pkg::S_FLOAT;
                end else if (start_cks) begin
                    next_st = blhbc_pkg::S_ADDR;
                end else if (start_user) begin
                    // plain and iack transfers ignore the line; atomic ones wait for it
                    if (req_atomic_i && !lock_in_i) begin
                        next_st = blhbc_pkg::S_LOCKWAIT;
                    end else begin
                        next_st = blhbc_pkg::S_ADDR;
                    end
                end
            end
            blhbc_pkg::S_LOCKWAIT: begin
                if (hold_i) begin
                    next_st = blhbc_pkg::S_FLOAT;          // retried after hold
                end else if (lock_in_i) begin
                    next_st = blhbc_pkg::S_ADDR;
                end
            end
            blhbc_pkg::S_ADDR: next_st = blhbc_pkg::S_DATA;
            blhbc_pkg::S_DATA, blhbc_pkg::S_WAIT: begin
                if (ready_n_i) begin
                    next_st = blhbc_pkg::S_WAIT;
                end else if (beat != last) begin
                    next_st = blhbc_pkg::S_DATA;
                end else if (xatomic && !xwrite) begin
                    next_st = blhbc_pkg::S_ADDR;           // write half follows
                end else begin
                    next_st = blhbc_pkg::S_IDLE;
                end
            end
            blhbc_pkg::S_FLOAT: next_st = blhbc_pkg::S_HOLD;
            blhbc_pkg::S_HOLD: begin
                if (!hold_i) begin
                    next_st = blhbc_pkg::S_IDLE;
                end
            end
            default: next_st = blhbc_pkg::S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st <= blhbc_pkg::S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // transfer attributes
    // ********************************************************
    // latched at the start; atomic flips to write after the read half
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            xwrite  <= 1'b0;
            xatomic <= 1'b0;
            xiack   <= 1'b0;
            xcks    <= 1'b0;
            last    <= blhbc_pkg::BEAT_FIRST;
            lanes_n <= blhbc_pkg::LANES_OFF_N;
        end else if (next_st == blhbc_pkg::S_ADDR && !in_data(st)) begin
            xwrite  <= !start_cks && req_write_i && !req_atomic_i && !req_iack_i;
            xatomic <= !start_cks && req_atomic_i;
            xiack   <= !start_cks && req_iack_i && !req_atomic_i;
            xcks    <= start_cks;
            last    <= start_cks ? blhbc_pkg::CKS_LAST_BEAT : req_beats_i;
            lanes_n <= start_cks ? blhbc_pkg::LANES_ALL_N : req_lanes_n_i;
        end else if (next_st == blhbc_pkg::S_ADDR) begin
            xwrite  <= 1'b1;
        end
    end

    // beat counter holds through waits
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            beat <= blhbc_pkg::BEAT_FIRST;
        end else if (next_st == blhbc_pkg::S_ADDR) begin
            beat <= blhbc_pkg::BEAT_FIRST;
        end else if (beat_ok && beat != last) begin
            beat <= beat + 3'h1;
        end
    end

    // checksum words to the start-up sequencer
    assign init.beat_valid = xcks && beat_ok;
    assign init.beat_data  = rd_data_i;
    assign init.burst_end  = xcks && finish;

    // ********************************************************
    // lock line
    // ********************************************************
    // set on read address state, drop on the write address state
    always_comb begin
        next_lock = lock_held;
        if (next_st == blhbc_pkg::S_ADDR && !in_data(st)) begin
            next_lock = (start_user && (req_atomic_i || req_iack_i));
        end else if (next_st == blhbc_pkg::S_ADDR) begin
            next_lock = 1'b0;
        end else if (finish && next_st == blhbc_pkg::S_IDLE) begin
            next_lock = 1'b0;                                         // iack ends
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            lock_held   <= 1'b0;
            lock_out_o  <= 1'b0;
            lock_oe_n_o <= 1'b1;
        end else begin
            lock_held   <= next_lock;
            lock_out_o  <= 1'b0;                     // open drain pulls low only
            lock_oe_n_o <= !(next_lock && !once);
        end
    end

    // ********************************************************
    // pin outputs
    // ********************************************************
    // registered from the next state so pins line up with the state
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            address_state_o        <= 1'b0;
            data_state_o           <= 1'b0;
            write_o                <= 1'b0;
            byte_lane_enables_n_o  <= blhbc_pkg::LANES_OFF_N;
            burst_final_strobe_n_o <= 1'b1;
            init_fail_o            <= 1'b0;
            req_done_o             <= 1'b0;
        end else begin
            address_state_o <= (next_st == blhbc_pkg::S_ADDR);
            data_state_o    <= in_data(next_st);
            // a new transfer shows its own direction, not the one latched before it
            write_o         <= (next_st != blhbc_pkg::S_ADDR) ? xwrite
                             : in_data(st) ? 1'b1
                             : (!start_cks && req_write_i && !req_atomic_i && !req_iack_i);
            byte_lane_enables_n_o <= in_data(next_st) ? lanes_n
                                                      : blhbc_pkg::LANES_OFF_N;
            // low on the last beat and its waits, or as start-up error code
            burst_final_strobe_n_o <= !((in_data(next_st) && (in_data(st) ? (beat == last
                                      || (beat_ok && beat + 3'h1 == last)) : last
                                      == blhbc_pkg::BEAT_FIRST)) || init.fail);
            init_fail_o <= init.fail;
            req_done_o  <= finish && !xcks && next_st == blhbc_pkg::S_IDLE;
        end
    end

    // hold handover: float in one cycle, acknowledge in the next
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            bus_grant_ack_o      <= 1'b0;
            bus_grant_ack_oe_n_o <= 1'b0;
            bus_float_o          <= 1'b1;        // released while in reset
        end else begin
            bus_grant_ack_o      <= (next_st == blhbc_pkg::S_HOLD);
            bus_grant_ack_oe_n_o <= once;        // float mode overrides drive
            bus_float_o          <= once || next_st == blhbc_pkg::S_FLOAT
                                    || next_st == blhbc_pkg::S_HOLD;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_release;
        bus_float_o && !bus_grant_ack_o ##1 bus_float_o && bus_grant_ack_o;
    endsequence

    a_lock_wait: assert property ((st == blhbc_pkg::S_LOCKWAIT && !lock_in_i)
        |=> !address_state_o && lock_oe_n_o) else $error("atomic began on held lock");
    a_lock_read: assert property ((address_state_o && xatomic && !write_o)
        |-> !lock_oe_n_o) else $error("lock not driven in read address state");
    a_lock_write: assert property ((address_state_o && xatomic && write_o)
        |-> lock_oe_n_o) else $error("lock still driven in write address state");
    a_lock_iack: assert property ((data_state_o && xiack) |-> !lock_oe_n_o)
        else $error("lock not driven during interrupt acknowledge");
    // pins pick up float mode one edge after release, reset values stand before that
    a_once_float: assert property ((once && $past(rstn_i))
        |-> bus_float_o && lock_oe_n_o && bus_grant_ack_oe_n_o)
        else $error("output driven in float mode");
    a_lane_idle: assert property (!data_state_o |-> byte_lane_enables_n_o == 2'h3)
        else $error("lane enable outside data state");
    a_fail_code: assert property (init_fail_o |-> !burst_final_strobe_n_o
        && byte_lane_enables_n_o == 2'h3) else $error("start-up error code wrong");
    a_hold_order: assert property (($rose(bus_float_o) && !once) |-> s_release)
        else $error("grant ack not after float");
    a_hold_exit: assert property ((bus_grant_ack_o && !hold_i)
        |=> !bus_grant_ack_o && (!bus_float_o || once)) else $error("hold exit wrong");
    a_wait_stretch: assert property ((data_state_o && ready_n_i)
        |=> data_state_o && $stable(beat)) else $error("data state not stretched");
    a_final_wait: assert property ((data_state_o && !burst_final_strobe_n_o && ready_n_i)
        |=> !burst_final_strobe_n_o) else $error("final strobe lost in wait");
endmodule // blhbc_bus

// ### hdl/blhbc_init.sv
module blhbc_init #(
    parameter int unsigned SELFTEST_CYCLES = blhbc_pkg::SELFTEST_CYCLES
) (
    input  wire logic     mclk_i,
    input  wire logic     rstn_i,
    input  wire logic     selftest_ok_i,
    blhbc_init_if.startup init
);
    localparam int unsigned CW = $clog2(SELFTEST_CYCLES + 1);
    localparam logic [CW-1:0] TEST_END = CW'(SELFTEST_CYCLES - 1);

    blhbc_pkg::blhbc_init_state_t st;       // start-up phase
    logic [CW-1:0]                cnt;      // self-test cycle count
    logic [15:0]                  sum;      // running checksum
    logic [15:0]                  next_sum; // sum including this word

    // ********************************************************
    // sequencing
    // ********************************************************
    assign next_sum = sum + (init.beat_valid ? init.beat_data : 16'h0000);

    // phase walk: test, checksum, then run or dead for good
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st <= blhbc_pkg::I_TEST;
        end else begin
            case (st)
                blhbc_pkg::I_TEST: begin
                    if (cnt == TEST_END) begin
                        st <= selftest_ok_i ? blhbc_pkg::I_CKS : blhbc_pkg::I_DEAD;
                    end
                end
                blhbc_pkg::I_CKS: begin
                    if (init.burst_end) begin
                        st <= (next_sum == blhbc_pkg::CKS_GOOD) ? blhbc_pkg::I_RUN
                                                                : blhbc_pkg::I_DEAD;
                    end
                end
                blhbc_pkg::I_RUN:  st <= blhbc_pkg::I_RUN;
                blhbc_pkg::I_DEAD: st <= blhbc_pkg::I_DEAD; // only reset leaves
                default:           st <= blhbc_pkg::I_DEAD;
            endcase
        end
    end

    // self-test timer
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cnt <= '0;
        end else if (st == blhbc_pkg::I_TEST) begin
            cnt <= cnt + CW'(1);
        end
    end

    // checksum accumulator
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            sum <= 16'h0000;
        end else if (st == blhbc_pkg::I_CKS) begin
            sum <= next_sum;
        end
    end

    // error shown during test and after any failure
    assign init.fail    = (st == blhbc_pkg::I_TEST) || (st == blhbc_pkg::I_DEAD);
    assign init.cks_req = (st == blhbc_pkg::I_CKS);

    // ********************************************************
    // checks
    // ********************************************************
    a_dead_sticky: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st == blhbc_pkg::I_DEAD) |=> init.fail [*4])
        else $error("start-up error indication dropped after failure");
    a_cks_verdict: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st == blhbc_pkg::I_CKS && init.burst_end && next_sum != 16'h0000) |=> init.fail)
        else $error("bad checksum did not raise error");
endmodule // blhbc_init

// ### hdl/blhbc_init_if.sv
// start-up sequencer to bus sequencer link
interface blhbc_init_if;
    logic        fail;       // start-up error indication
    logic        cks_req;    // checksum burst wanted
    logic        beat_valid; // checksum word accepted this cycle
    logic [15:0] beat_data;  // word being summed
    logic        burst_end;  // last checksum word accepted
    modport startup (output fail, output cks_req,
                     input beat_valid, input beat_data, input burst_end);
    modport bus     (input fail, input cks_req,
                     output beat_valid, output beat_data, output burst_end);
endinterface

// ### hdl/blhbc_pkg.sv
package blhbc_pkg;
    // ********************************************************
    // timing and counts
    // ********************************************************
    localparam int unsigned SELFTEST_CYCLES = 24000;  // self-test length in cycles
    localparam logic [2:0]  CKS_LAST_BEAT   = 3'h7;   // eight words summed
    localparam logic [1:0]  LANES_OFF_N     = 2'h3;   // both enables deasserted
    localparam logic [1:0]  LANES_ALL_N     = 2'h0;   // both lanes active
    localparam logic [15:0] CKS_GOOD        = 16'h0000; // zero checksum target
    localparam logic [2:0]  BEAT_FIRST      = 3'h0;   // first beat index

    // ********************************************************
    // state types
    // ********************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_LOCKWAIT, S_ADDR, S_DATA, S_WAIT, S_FLOAT, S_HOLD
    } blhbc_bus_state_t;

    typedef enum logic [2:0] {
        I_TEST, I_CKS, I_RUN, I_DEAD
    } blhbc_init_state_t;
endpackage

// ### tb/blhbc_mem.sv
// memory partner: serves beats with a set number of waits
module blhbc_mem (
    input  wire logic        mclk_i,
    input  wire logic        data_state_i, // design in data or wait state
    input  wire logic [1:0]  waits_i,      // waits before each ready
    input  wire logic        bad_i,        // corrupt the boot image
    output logic             ready_n_o,    // ready, low active
    output logic [15:0]      rd_data_o     // read word
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************************************************
    // beat and wait tracking
    // ********************************************************
    logic [1:0] wc   = 2'h0; // waits served in this beat
    logic [2:0] beat = 3'h0; // beat index within the burst
    logic       tog  = 1'b0; // idle pattern, so no stale value lingers
    logic       rdy;         // ready given this cycle
    assign rdy = data_state_i && (wc == waits_i);
    assign ready_n_o = data_state_i ? !rdy : tog;
    // words 0..6 then the negated sum, so the image checks to zero
    assign rd_data_o = !rdy ? {16{tog}} :
        (beat == 3'h7) ? 16'hffeb + {15'h0, bad_i} : {13'h0, beat};
    // wait counter restarts per beat, beat count per burst
    always_ff @(posedge mclk_i) begin
        tog <= !tog;
        if (!data_state_i) begin
            beat <= 3'h0;
            wc   <= 2'h0;
        end else if (rdy) begin
            beat <= beat + 3'h1;
            wc   <= 2'h0;
        end else begin
            wc <= wc + 2'h1;
        end
    end
endmodule // blhbc_mem

// ### tb/bus_lock_hold_burst_control_bench.sv
module bus_lock_hold_burst_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************************************************
    // stimulus and observed signals
    // ********************************************************
    logic mclk_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, wr = 1'b0, at = 1'b0, ia = 1'b0;
    logic [2:0] beats = 3'h0;
    logic [1:0] lanes = 2'h3, waits = 2'h0, be_n;
    logic hold = 1'b0, oth = 1'b0, bad = 1'b0; // oth: other agent pulls lock
    logic done, lk_out, lk_oe_n, strb_n, ack, ack_oe_n, flt, ast, ds, wo, fail, rdy_n, lock_w;
    logic [15:0] rdat;
    logic la [0:3]; // lock wire level seen at each address state
    logic lw [0:3]; // write_o seen at each address state
    int err_total = 0, tests_run = 0, na, nd, ns, nl, lb, to;
    // open-drain lock wire with pull-up, either party may pull
    assign lock_w = !(oth || (!lk_oe_n && !lk_out));
    blhbc_bus #(.SELFTEST_CYCLES(20)) i_blhbc_bus (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .selftest_ok_i(1'b1), .req_i(req_i),
        .req_write_i(wr), .req_atomic_i(at), .req_iack_i(ia), .req_beats_i(beats),
        .req_lanes_n_i(lanes), .req_done_o(done), .rd_data_i(rdat), .ready_n_i(rdy_n),
        .hold_i(hold), .lock_in_i(lock_w), .lock_out_o(lk_out), .lock_oe_n_o(lk_oe_n),
        .byte_lane_enables_n_o(be_n), .burst_final_strobe_n_o(strb_n),
        .bus_grant_ack_o(ack), .bus_grant_ack_oe_n_o(ack_oe_n), .bus_float_o(flt),
        .address_state_o(ast), .data_state_o(ds), .write_o(wo), .init_fail_o(fail));
    blhbc_mem i_blhbc_mem (.mclk_i(mclk_i), .data_state_i(ds), .waits_i(waits),
        .bad_i(bad), .ready_n_o(rdy_n), .rd_data_o(rdat));
    initial forever #4 mclk_i = ~mclk_i;
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic rst(input logic pull, input logic b);
        rstn_i = 1'b0;
        oth = pull;
        bad = b;
        step(2);
        chk(16'(ack), 16'h0);
        chk(16'(flt), 16'h1);
        rstn_i = 1'b1;
        step(1);
        oth = 1'b0;
    endtask
    // one idle edge first, so req_i never rises in the step that dropped it
    task automatic start(input logic w, a, i, input logic [2:0] b, input logic [1:0] l);
        step(1);
        wr = w;
        at = a;
        ia = i;
        beats = b;
        lanes = l;
        req_i = 1'b1;
    endtask
    // follow one request to its done pulse, tallying states
    task automatic run();
        na = 0;
        nd = 0;
        ns = 0;
        nl = 0;
        lb = 0;
        for (to = 0; to < 200; to++) begin
            step(1);
            if (ast === 1'b1) begin
                la[na] = lock_w;
                lw[na] = wo;
                na++;
            end
            if (ds === 1'b1) begin
                nd++;
                if (be_n !== lanes) lb++;
                if (strb_n === 1'b0) ns++;
            end
            if (lk_oe_n === 1'b0) nl++;
            if (done === 1'b1) break;
        end
        req_i = 1'b0; // dropped before the edge after done
        chk(16'(done), 16'h1);
    endtask
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic boot(input logic b);
        rst(1'b0, b);
        chk(16'({strb_n, be_n, fail}), 16'h7);
        for (to = 0; to < 40 && fail !== 1'b0; to++) step(1);
        chk(16'(fail), 16'h0);
        step(40);
        chk(16'({strb_n, be_n, fail}), b ? 16'h7 : 16'he);
        $display("boot test done, bad image %0d", b);
    endtask
    task automatic t_read();
        waits = 2'h2;
        start(1'b0, 1'b0, 1'b0, 3'h3, 2'h2);
        run();
        chk(16'(nd), 16'd12);
        chk(16'(ns), 16'd3);
        chk(16'(lb), 16'd0);
        waits = 2'h0;
        start(1'b1, 1'b0, 1'b0, 3'h0, 2'h1);
        run();
        chk(16'({nd[3:0], ns[3:0], lb[3:0]}), 16'h110);
        $display("read write test done");
    endtask
    task automatic t_atomic();
        oth = 1'b1;
        start(1'b0, 1'b1, 1'b0, 3'h1, 2'h0);
        step(10);
        chk(16'({ast, lk_oe_n}), 16'h1);
        oth = 1'b0;
        run();
        chk(16'(na), 16'd2);
        // read half pulls the wire low, write half lets it go; direction shown in each
        chk(16'({la[0], lw[0]}), 16'h0);
        chk(16'({la[1], lw[1]}), 16'h3);
        chk(16'({nd[3:0], ns[3:0]}), 16'h42);
        $display("atomic test done");
    endtask
    task automatic t_iack();
        waits = 2'h1;
        start(1'b0, 1'b0, 1'b1, 3'h0, 2'h0);
        run();
        chk(16'(nl), 16'(na + nd));
        chk(16'(nd), 16'd2);
        $display("iack test done");
    endtask
    task automatic t_hold();
        hold = 1'b1;
        step(1);
        chk(16'({flt, ack}), 16'h2);
        step(1);
        chk(16'({ack, ack_oe_n}), 16'h2);
        hold = 1'b0;
        step(1);
        chk(16'({flt, ack}), 16'h0);
        $display("hold test done");
    endtask
    task automatic t_float();
        rst(1'b1, 1'b0);
        start(1'b0, 1'b0, 1'b0, 3'h0, 2'h0);
        step(40);
        chk(16'({flt, ack_oe_n, lk_oe_n, ast}), 16'he);
        req_i = 1'b0;
        $display("float mode test done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #40000;
        err_total++;
        summarize();
    end
    initial begin
        boot(1'b0);
        t_read();
        t_atomic();
        t_iack();
        t_hold();
        boot(1'b1);
        t_float();
        summarize();
    end
endmodule // bus_lock_hold_burst_control_bench
